//--- inc/psc_defines.svh
// Constants for the power state pin control block.
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
`define PSC_SYNC_STAGES 2
`define PSC_IF_UART     2'b11
`define PSC_IF_TWI      2'b01
`define PSC_IF_SPI      2'b10
`define PSC_STATE_RESET 1'b0
`endif

//--- inc/psc_pkg.sv
// Types for the power state pin control block.
package psc_pkg;
	typedef enum logic [2:0] {PSC_SLEEP, PSC_FULL, PSC_FIX_DEMAND, PSC_DUTY, PSC_HALTED} psc_state_t;
	typedef enum logic [1:0] {PSC_HOST_UART, PSC_HOST_TWI, PSC_HOST_SPI} psc_host_t;
endpackage

//--- logic/psc_sync.sv
// Two flip-flop synchroniser for one level input.
`timescale 1ns/1ps
module psc_sync
(
	input  wire logic clk_sys_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	input  wire logic d_in,
	input  wire logic init_in,
	output logic      q_out
);
	logic meta_reg;
	logic q_reg;
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta_reg <= 1'b1;
			q_reg    <= 1'b1;
		end
		else if (ce_in)
		begin
			meta_reg <= d_in;
			q_reg    <= meta_reg;
		end
	end
	assign q_out = q_reg;
endmodule

//--- logic/psc_power_ctrl.sv
// Power state control and host pin routing.
`timescale 1ns/1ps
`include "psc_defines.svh"
// How it works
// [R01] Synchronised power request high gives sleep, low gives full power.
// [R02] State changes only when a new request level arrives; the code also moves on halt, on fix or duty entry and on fix_done_in.
// [R03] Request change leaves fix-on-demand or duty mode for full power; from fix-on-demand the code returns there on fix_done_in.
// [R04] Status output low in sleep, high at full power.
// [R05] Host must drive the power request input.
// [R06] Halt input pulled up inactive; driven low it interrupts operation.
// [R07] Serial mode: receive and clear-to-send in, transmit and request-to-send out.
// [R08] Two-wire mode: receive is data, transmit is clock, both two-way.
// [R09] Four-wire slave: data in, clock, select inputs; data out on transmit.
// [R10] Active-low flow control pins pick the host interface.
// [R11] Power request input is synchronised before use.
module psc_power_ctrl
(
	input  wire logic             clk_sys_in,
	input  wire logic             rst_in,
	input  wire logic             ce_in,
	input  wire logic             power_req_in,
	input  wire logic             halt_n_in,
	input  wire logic             enter_fix_demand_in,
	input  wire logic             enter_duty_in,
	input  wire logic             fix_done_in,
	input  wire logic             rx_pin_in,
	output logic                  rx_pin_out,
	output logic                  rx_pin_oe_out,
	input  wire logic             tx_pin_in,
	output logic                  tx_pin_out,
	output logic                  tx_pin_oe_out,
	input  wire logic             cts_n_pin_in,
	output logic                  cts_n_pin_out,
	output logic                  cts_n_pin_oe_out,
	input  wire logic             rts_n_pin_in,
	output logic                  rts_n_pin_out,
	output logic                  rts_n_pin_oe_out,
	input  wire logic             uart_txd_in,
	input  wire logic             uart_rts_n_in,
	output logic                  uart_rxd_out,
	output logic                  uart_cts_n_out,
	input  wire logic             twi_sda_drive_low_in,
	input  wire logic             twi_scl_drive_low_in,
	output logic                  twi_sda_out,
	output logic                  twi_scl_out,
	input  wire logic             spi_miso_in,
	output logic                  spi_mosi_out,
	output logic                  spi_sclk_out,
	output logic                  spi_cs_n_out,
	output psc_pkg::psc_host_t    host_sel_out,
	output psc_pkg::psc_state_t   state_out,
	output logic                  wake_status_out
);
	import psc_pkg::*;
	logic       req_sync;
	logic       req_prev_reg;
	logic       req_change;
	psc_state_t state_reg;
	psc_state_t state_next;
	psc_host_t  host_reg;
	logic       wake_reg;
	logic       strap_done_reg;
	logic       fix_wake_reg;

	psc_sync u_req_sync
	(
		.clk_sys_in (clk_sys_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.d_in       (power_req_in),
		.init_in    (1'b1),
		.q_out      (req_sync)
	);

	// A request edge is seen only after synchronising. [R11]
	assign req_change = req_sync != req_prev_reg;

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			req_prev_reg <= 1'b1;
		else if (ce_in)
			req_prev_reg <= req_sync;
	end

	always_comb
	begin
		state_next = state_reg;
		if (!halt_n_in)
			state_next = PSC_HALTED; // [R06]
		else
		begin
			case (state_reg)
				PSC_SLEEP:
					if (req_change && !req_sync)
						state_next = PSC_FULL; // [R01] [R02]
				PSC_FULL:
					if (req_change && req_sync)
						state_next = PSC_SLEEP; // [R01] [R02]
					else if (enter_fix_demand_in)
						state_next = PSC_FIX_DEMAND;
					else if (enter_duty_in)
						state_next = PSC_DUTY;
				PSC_FIX_DEMAND:
					if (req_change)
						state_next = PSC_FULL; // [R03]
				PSC_DUTY:
					if (req_change)
						state_next = PSC_FULL; // [R03]
				PSC_HALTED:
					state_next = req_sync ? PSC_SLEEP : PSC_FULL;
				default:
					state_next = PSC_SLEEP;
			endcase
		end
		// The fix sends a fix-on-demand wake back, so status follows the real state.
		if (halt_n_in && fix_wake_reg && fix_done_in && state_next == PSC_FULL)
			state_next = PSC_FIX_DEMAND; // [R03]
	end

	// Fix-on-demand wake lasts until the fix or until full power is left; the fix drops it back.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			fix_wake_reg <= 1'b0;
		else if (ce_in)
		begin
			if (state_reg == PSC_FIX_DEMAND && req_change)
				fix_wake_reg <= 1'b1; // [R03]
			else if (fix_done_in || state_reg != PSC_FULL)
				fix_wake_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			state_reg <= PSC_SLEEP;
		else if (ce_in)
			state_reg <= state_next; // [R03]
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			wake_reg <= `PSC_STATE_RESET;
		else if (ce_in)
			wake_reg <= (state_next == PSC_FULL); // [R04]
	end

	// Interface is chosen once, after reset release, from the flow pins. [R10]
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			host_reg       <= PSC_HOST_UART;
			strap_done_reg <= 1'b0;
		end
		else if (ce_in && !strap_done_reg)
		begin
			strap_done_reg <= 1'b1;
			case ({cts_n_pin_in, rts_n_pin_in})
				`PSC_IF_TWI: host_reg <= PSC_HOST_TWI; // [R10]
				`PSC_IF_SPI: host_reg <= PSC_HOST_SPI; // [R10]
				default:     host_reg <= PSC_HOST_UART;
			endcase
		end
	end

	always_comb
	begin
		rx_pin_out       = 1'b0;
		rx_pin_oe_out    = 1'b0;
		tx_pin_out       = 1'b1;
		tx_pin_oe_out    = 1'b0;
		cts_n_pin_out    = 1'b1;
		cts_n_pin_oe_out = 1'b0;
		rts_n_pin_out    = 1'b1;
		rts_n_pin_oe_out = 1'b0;
		uart_rxd_out     = 1'b1;
		uart_cts_n_out   = 1'b1;
		twi_sda_out      = 1'b1;
		twi_scl_out      = 1'b1;
		spi_mosi_out     = 1'b0;
		spi_sclk_out     = 1'b0;
		spi_cs_n_out     = 1'b1;
		case (host_reg)
			PSC_HOST_UART:
			begin
				uart_rxd_out     = rx_pin_in; // [R07]
				uart_cts_n_out   = cts_n_pin_in; // [R07]
				tx_pin_out       = uart_txd_in; // [R07]
				tx_pin_oe_out    = 1'b1;
				rts_n_pin_out    = uart_rts_n_in; // [R07]
				rts_n_pin_oe_out = 1'b1;
			end
			PSC_HOST_TWI:
			begin
				twi_sda_out   = rx_pin_in; // [R08]
				rx_pin_oe_out = twi_sda_drive_low_in; // [R08]
				twi_scl_out   = tx_pin_in; // [R08]
				tx_pin_oe_out = twi_scl_drive_low_in; // [R08]
				tx_pin_out    = 1'b0;
			end
			PSC_HOST_SPI:
			begin
				spi_mosi_out  = rx_pin_in; // [R09]
				spi_sclk_out  = cts_n_pin_in; // [R09]
				spi_cs_n_out  = rts_n_pin_in; // [R09]
				tx_pin_out    = spi_miso_in; // [R09]
				tx_pin_oe_out = 1'b1;
			end
			default:
			begin
				tx_pin_oe_out = 1'b0;
			end
		endcase
	end

	assign host_sel_out    = host_reg;
	assign state_out       = state_reg;
	assign wake_status_out = wake_reg;

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sleep_entry_a: assert property ((ce_in && halt_n_in && state_reg == PSC_FULL && req_change
		&& req_sync) |=> state_reg == PSC_SLEEP) // [R01]
		else $error("Sleep not entered on high request.");
	wake_entry_a: assert property ((ce_in && halt_n_in && state_reg == PSC_SLEEP && req_change
		&& !req_sync) |=> state_reg == PSC_FULL) // [R01]
		else $error("Full power not entered on low request.");
	stay_put_a: assert property ((ce_in && halt_n_in && !req_change && state_reg == PSC_SLEEP)
		|=> state_reg == PSC_SLEEP) // [R02]
		else $error("Sleep left without a request change.");
	duty_exit_a: assert property ((ce_in && halt_n_in && state_reg == PSC_DUTY && req_change)
		|=> state_reg == PSC_FULL) // [R03]
		else $error("Duty mode not left on request change.");
	status_level_a: assert property (wake_status_out == (state_reg == PSC_FULL)) // [R04]
		else $error("Status low at full power.");
	halt_stop_a: assert property ((ce_in && !halt_n_in) |=> state_reg == PSC_HALTED) // [R06]
		else $error("Halt input did not stop operation.");
	uart_route_a: assert property (host_reg == PSC_HOST_UART |-> tx_pin_oe_out
		&& rts_n_pin_oe_out && !rx_pin_oe_out && !cts_n_pin_oe_out) // [R07]
		else $error("Serial pin directions wrong.");
	spi_route_a: assert property (host_reg == PSC_HOST_SPI |-> tx_pin_oe_out
		&& spi_sclk_out == cts_n_pin_in && !rts_n_pin_oe_out) // [R09]
		else $error("Four-wire pin routing wrong.");
	sync_delay_a: assert property ((ce_in && $stable(power_req_in)) [*3]
		|-> req_sync == power_req_in) // [R11]
		else $error("Request not passed through synchroniser.");

	wake_c: cover property (state_reg == PSC_SLEEP ##1 state_reg == PSC_FULL);
	fix_c: cover property (state_reg == PSC_FIX_DEMAND ##1 state_reg == PSC_FULL);
	halt_c: cover property (state_reg == PSC_HALTED);
	twi_c: cover property (host_reg == PSC_HOST_TWI);
endmodule

//--- verification/psc_host_model.sv
// Host side model driving the power request, halt and shared serial pins.
`timescale 1ns/1ps
module psc_host_model
(
	input  wire logic       clk_sys_in,
	input  wire logic [3:0] dev_out_in,
	input  wire logic [3:0] dev_oe_in,
	output logic            power_req_out,
	output logic            halt_n_out,
	output logic [3:0]      pin_out
);
	logic       req_reg;
	logic       halt_reg;
	logic [3:0] host_reg;
	// The host always drives the request level.
	assign power_req_out = req_reg;
	// The halt line floats high through its pull-up unless pulled low.
	assign halt_n_out = !halt_reg;
	// Pins are pulled up and either side may pull a line low.
	assign pin_out = (dev_out_in | ~dev_oe_in) & host_reg;
	initial
	begin
		req_reg = 1'b1;
		halt_reg = 1'b0;
		host_reg = 4'hf;
	end
	// Changes the host levels just after a falling edge.
	task automatic drive(input logic r, input logic h, input logic [3:0] p);
		@(negedge clk_sys_in);
		req_reg = r;
		halt_reg = h;
		host_reg = p;
	endtask
endmodule

//--- verification/power_state_pin_control_test.sv
// Testbench for the power state pin control block.
`timescale 1ns/1ps
module power_state_pin_control_test;
	import psc_pkg::*;
	logic       clk_sys_in = 1'b0;
	logic       rst_in = 1'b1;
	logic       ce = 1'b1;
	logic       req, halt_n, fix_d = 1'b0, en_fix = 1'b0, en_duty = 1'b0;
	logic       txd = 1'b1, rts_n = 1'b1, sda_lo = 1'b0, scl_lo = 1'b0, miso = 1'b1;
	logic       rxd, cts_n, sda, scl, mosi, sclk, cs_n, wake;
	logic [3:0] pins, outs, oe;
	psc_host_t  host_sel;
	psc_state_t state;
	int         n_mismatch = 0;
	int         n_compared = 0;
	int         cycles = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	psc_host_model i_psc_host_model (.clk_sys_in(clk_sys_in), .dev_out_in(outs),
		.dev_oe_in(oe), .power_req_out(req), .halt_n_out(halt_n), .pin_out(pins));
	psc_power_ctrl i_psc_power_ctrl (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
		.power_req_in(req), .halt_n_in(halt_n), .enter_fix_demand_in(en_fix),
		.enter_duty_in(en_duty), .fix_done_in(fix_d),
		.rx_pin_in(pins[3]), .rx_pin_out(outs[3]), .rx_pin_oe_out(oe[3]),
		.tx_pin_in(pins[2]), .tx_pin_out(outs[2]), .tx_pin_oe_out(oe[2]),
		.cts_n_pin_in(pins[1]), .cts_n_pin_out(outs[1]), .cts_n_pin_oe_out(oe[1]),
		.rts_n_pin_in(pins[0]), .rts_n_pin_out(outs[0]), .rts_n_pin_oe_out(oe[0]),
		.uart_txd_in(txd), .uart_rts_n_in(rts_n), .uart_rxd_out(rxd), .uart_cts_n_out(cts_n),
		.twi_sda_drive_low_in(sda_lo), .twi_scl_drive_low_in(scl_lo), .twi_sda_out(sda),
		.twi_scl_out(scl), .spi_miso_in(miso), .spi_mosi_out(mosi), .spi_sclk_out(sclk),
		.spi_cs_n_out(cs_n), .host_sel_out(host_sel), .state_out(state),
		.wake_status_out(wake));
	task automatic wrap_up;
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	// Waits a bounded time for a state, then compares it.
	task automatic wait_st(input psc_state_t s);
		repeat (8) if (state !== s) tick(1);
		chk(state, s);
	endtask
	task automatic do_reset(input logic [3:0] p);
		i_psc_host_model.drive(1'b1, 1'b0, p);
		rst_in = 1'b1;
		tick(3);
		rst_in = 1'b0;
		tick(2);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic t_power;
		i_psc_host_model.drive(1'b0, 1'b0, 4'hf);
		tick(2);
		chk(state, PSC_SLEEP);
		tick(1);
		chk({wake, state}, {1'b1, PSC_FULL});
		tick(10);
		chk(state, PSC_FULL);
	endtask
	task automatic t_uart;
		txd = 1'b0;
		rts_n = 1'b0;
		i_psc_host_model.drive(1'b0, 1'b0, 4'b0111);
		tick(1);
		chk({rxd, cts_n, pins[2], pins[0]}, 4'b0100);
		chk(oe, 4'b0101);
		txd = 1'b1;
		rts_n = 1'b1;
	endtask
	task automatic t_modes;
		pulse(en_fix);
		wait_st(PSC_FIX_DEMAND);
		i_psc_host_model.drive(1'b1, 1'b0, 4'hf);
		wait_st(PSC_FULL);
		pulse(fix_d);
		wait_st(PSC_FIX_DEMAND);
		chk(wake, 1'b0);
		i_psc_host_model.drive(1'b0, 1'b0, 4'hf);
		wait_st(PSC_FULL);
		pulse(en_duty);
		wait_st(PSC_DUTY);
		i_psc_host_model.drive(1'b1, 1'b0, 4'hf);
		wait_st(PSC_FULL);
	endtask
	task automatic t_halt;
		i_psc_host_model.drive(1'b1, 1'b1, 4'hf);
		wait_st(PSC_HALTED);
		i_psc_host_model.drive(1'b1, 1'b0, 4'hf);
		wait_st(PSC_SLEEP);
		chk(wake, 1'b0);
	endtask
	// A low clock enable holds the state although the request changes.
	task automatic t_freeze;
		ce = 1'b0;
		i_psc_host_model.drive(1'b0, 1'b0, 4'hf);
		tick(6);
		chk({wake, state}, {1'b0, PSC_SLEEP});
		ce = 1'b1;
		wait_st(PSC_FULL);
		i_psc_host_model.drive(1'b1, 1'b0, 4'hf);
		wait_st(PSC_SLEEP);
	endtask
	task automatic t_strap;
		do_reset(4'b1101);
		chk(host_sel, PSC_HOST_TWI);
		scl_lo = 1'b1;
		tick(1);
		chk({pins[3], pins[2], sda, scl}, 4'b1010);
		scl_lo = 1'b0;
		sda_lo = 1'b1;
		tick(1);
		chk({pins[3], pins[2], sda, scl}, 4'b0101);
		sda_lo = 1'b0;
		do_reset(4'b1110);
		chk(host_sel, PSC_HOST_SPI);
		miso = 1'b0;
		i_psc_host_model.drive(1'b1, 1'b0, 4'b0100);
		tick(1);
		chk({mosi, sclk, cs_n, pins[2]}, 4'h0);
		chk(oe, 4'b0100);
	endtask
	always @(posedge clk_sys_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial
	begin
		do_reset(4'hf);
		chk(host_sel, PSC_HOST_UART);
		chk({wake, state}, {1'b0, PSC_SLEEP});
		t_power();
		t_uart();
		t_modes();
		t_halt();
		t_freeze();
		t_strap();
		wrap_up();
	end
endmodule
